// ### core/adcrt_cfg.svh
// Constants for the read-triggered converter control block.
// Assumes inclusion by core design files only.
`ifndef ADCRT_CFG_SVH
`define ADCRT_CFG_SVH

`define ADCRT_DONE_BIT        31
`define ADCRT_SAMPLE_W        16
`define ADCRT_SLOW_SEL_BIT    16
`define ADCRT_DIV_FAST        4
`define ADCRT_DIV_SLOW        16
`define ADCRT_CONV_CLOCKS     16

`endif

// ### core/adcrt_clk_div.sv
// Converter clock enable generator: divides the reference tick by 4 or 16.
// Assumes ref_tick is one-cycle pulses synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "adcrt_cfg.svh"

module adcrt_clk_div #(
  parameter int DIV_FAST = `ADCRT_DIV_FAST,
  parameter int DIV_SLOW = `ADCRT_DIV_SLOW
) (
  input  wire logic clk,       // Bus clock
  input  wire logic rst,       // Synchronous reset, high
  input  wire logic ref_tick,  // Reference clock tick
  input  wire logic slow_sel,  // Divide by the slow ratio
  output logic      conv_tick  // Converter clock tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] last;
  logic       wrap;

  assign last  = slow_sel ? 8'(DIV_SLOW - 1) : 8'(DIV_FAST - 1);
  assign wrap  = ref_tick && (cnt_q >= last);
  assign cnt_d = !ref_tick ? cnt_q : (wrap ? 8'h00 : cnt_q + 8'h01);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q     <= 8'h00;
      conv_tick <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      conv_tick <= wrap;
    end
  end
endmodule
`default_nettype wire

// ### core/adcrt_pkg.sv
// Types for the read-triggered converter control block.
// Assumes nothing of its surroundings.
package adcrt_pkg;
  typedef enum logic [1:0] {
    ADCRT_IDLE,
    ADCRT_START,
    ADCRT_BUSY
  } adcrt_state_t;
endpackage

// ### core/adcrt_top.sv
// Read-triggered converter control: a result read starts a conversion.
// Assumes an analog front end that samples on start and offers data.
// Limitation: reads faster than the sample rate return stale samples.
`timescale 1ns/100ps
`default_nettype none
`include "adcrt_cfg.svh"

// What this block does
// - Reading the result register starts a new conversion.
// - Returned word holds the result and a converter status bit.
// - Reads during a conversion leave that conversion untouched.
// - Slow clock select is bit 16 of the clock divider register.
// - Converter clock is reference over 4, or over 16 when slow.
module adcrt_top #(
  parameter int CONV_CLOCKS = `ADCRT_CONV_CLOCKS,
  parameter int SAMPLE_W    = `ADCRT_SAMPLE_W
) (
  input  wire logic                clk,          // Bus clock, 200 MHz
  input  wire logic                rst,          // Synchronous reset, high
  input  wire logic                ref_tick,     // Reference clock tick
  input  wire logic [31:0]         clk_div_reg,  // Clock divider register
  input  wire logic                result_rd,    // Result register read strobe
  input  wire logic [SAMPLE_W-1:0] adc_data,     // Analog front end sample
  output logic      [31:0]         result_rdata, // Read data, one cycle later
  output logic                     conv_start,   // Sample and hold pulse
  output logic                     conv_busy,    // Conversion in progress
  output logic                     conv_tick_o   // Converter clock tick
);
  // Decoded control
  logic                    slow_clock_select;
  logic                    conv_tick;
  logic                    in_idle;
  logic                    in_busy;
  logic                    take_start;
  logic                    last_tick;
  logic                    conv_end;

  // Sequencer state and converter tick count
  adcrt_pkg::adcrt_state_t state_q;
  adcrt_pkg::adcrt_state_t state_d;
  logic [7:0]              tick_last;
  logic [7:0]              tick_inc;
  logic [7:0]              tick_cnt_q;
  logic [7:0]              tick_cnt_d;

  // Captured sample and completion status
  logic [SAMPLE_W-1:0]     sample_q;
  logic [SAMPLE_W-1:0]     sample_d;
  logic                    done_q;
  logic                    done_d;

  // Returned word and its fields
  logic                    rd_status;
  logic [30-SAMPLE_W:0]    rd_pad;
  logic [SAMPLE_W-1:0]     rd_sample;
  logic [31:0]             rd_word;

  // Output flip-flops
  logic [31:0]             rdata_q;
  logic [31:0]             rdata_d;
  logic                    start_q;
  logic                    start_d;
  logic                    busy_q;
  logic                    busy_d;
  logic                    tick_q;
  logic                    tick_d;

  assign slow_clock_select = clk_div_reg[`ADCRT_SLOW_SEL_BIT];

  // Divider ratios stay fixed; only the select moves at run time
  adcrt_clk_div #(
    .DIV_FAST (`ADCRT_DIV_FAST),
    .DIV_SLOW (`ADCRT_DIV_SLOW)
  ) u_div (
    .clk       (clk),
    .rst       (rst),
    .ref_tick  (ref_tick),
    .slow_sel  (slow_clock_select),
    .conv_tick (conv_tick)
  );

  assign in_idle    = (state_q == adcrt_pkg::ADCRT_IDLE);
  assign in_busy    = (state_q == adcrt_pkg::ADCRT_BUSY);

  // Reads while busy are ignored so the running conversion stays intact
  assign take_start = result_rd && in_idle;

  // Conversion length counted in converter ticks while busy
  assign tick_last  = 8'(CONV_CLOCKS - 1);
  assign tick_inc   = tick_cnt_q + 8'h01;
  assign last_tick  = (tick_cnt_q == tick_last);
  assign conv_end   = in_busy && conv_tick && last_tick;
  assign tick_cnt_d = !in_busy ? 8'h00 : (conv_tick ? tick_inc : tick_cnt_q);

  // Sequencer: idle, one start cycle for the hold, then busy to the last tick
  always_comb begin
    state_d = state_q;
    case (state_q)
      adcrt_pkg::ADCRT_IDLE: begin
        if (take_start) begin
          state_d = adcrt_pkg::ADCRT_START;
        end
      end
      adcrt_pkg::ADCRT_START: begin
        state_d = adcrt_pkg::ADCRT_BUSY;
      end
      adcrt_pkg::ADCRT_BUSY: begin
        if (conv_end) begin
          state_d = adcrt_pkg::ADCRT_IDLE;
        end
      end
      default: begin
        state_d = adcrt_pkg::ADCRT_IDLE;
      end
    endcase
  end

  // Word returned to software: status on top, sample in the low halfword
  assign rd_status = done_q;
  assign rd_pad    = '0;
  assign rd_sample = sample_q;
  assign rd_word   = {rd_status, rd_pad, rd_sample};
  assign rdata_d   = result_rd ? rd_word : rdata_q;

  // Sample moves only when a conversion ends
  assign sample_d  = conv_end ? adc_data : sample_q;

  // Done clears on a triggering read so polling sees fresh status; set wins
  always_comb begin
    done_d = done_q;
    if (conv_end) begin
      done_d = 1'b1;
    end else if (take_start) begin
      done_d = 1'b0;
    end
  end

  // Next values of the output flip-flops
  assign start_d   = take_start;
  assign busy_d    = (state_d != adcrt_pkg::ADCRT_IDLE);
  assign tick_d    = conv_tick;

  // Sequencer registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= adcrt_pkg::ADCRT_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // Result registers
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_q <= '0;
    end else begin
      sample_q <= sample_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Output registers
  always_ff @(posedge clk) begin
    if (rst) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
    end
  end

  // Outputs straight from flip-flops
  assign result_rdata = rdata_q;
  assign conv_start   = start_q;
  assign conv_busy    = busy_q;
  assign conv_tick_o  = tick_q;
endmodule
`default_nettype wire

// ### verification/adc_read_triggered_conversion_test.sv
// Bench: random samples polled through the software model.
// Assumes the core files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module adc_read_triggered_conversion_test;
  logic        clk = 1'b0, rst = 1'b1, rt = 1'b0, rd, tk, st;
  logic [31:0] dv = 32'h0, rdata, w;
  logic [15:0] adc = 16'h0000, exp_s;
  logic        bz;
  logic [15:0] model_q[$];
  bit          to;
  int          mismatches = 0, n_checks = 0, ns = 0, nt = 0, cyc = 0;
  always #2.5 clk = ~clk;
  always @(negedge clk) begin
    cyc++;
    rt <= (cyc % 14 == 0);
  end
  always @(posedge clk) begin
    ns += (st === 1'b1);
    nt += (tk === 1'b1);
  end
  adcrt_top #(.CONV_CLOCKS(2)) dut_u (.clk(clk), .rst(rst), .ref_tick(rt), .clk_div_reg(dv),
    .result_rd(rd), .adc_data(adc), .result_rdata(rdata), .conv_start(st), .conv_busy(bz),
    .conv_tick_o(tk));
  adcrt_sw_model sw_u (.clk(clk), .rdata(rdata), .rd(rd));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d bad %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(18));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 6; i++) begin
      adc = 16'($urandom);
      model_q.push_back(adc);
      dv = $urandom;
      repeat (140) @(negedge clk);
      nt = 0;
      // Window of exactly 48 reference ticks
      repeat (672) @(negedge clk);
      chk("ticks", 32'(nt), dv[16] ? 32'h3 : 32'hC);
      sw_u.poll(w, to);
      @(negedge clk);
      if (to) begin
        mismatches++;
        break;
      end
      exp_s = model_q.pop_front();
      chk("sample", w & 32'h0000FFFF, 32'(exp_s));
      chk("signed", 32'($signed(w[15:0])), {{16{exp_s[15]}}, exp_s});
      chk("busy", 32'(bz), 32'h00000001);
      chk("starts", 32'(ns), 32'(i + 2));
      $display("test %0d", i);
    end
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verification/adcrt_sva.sv
// Checker on adcrt_top ports.
// Assumes a bind into adcrt_top.
`timescale 1ns/100ps
`default_nettype none
module adcrt_sva (
  input wire logic        clk,          // Clock
  input wire logic        rst,          // Reset
  input wire logic        result_rd,    // Read
  input wire logic [31:0] result_rdata, // Data
  input wire logic        conv_start,   // Start
  input wire logic        conv_busy     // Busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence read_idle_s;
    result_rd && !conv_busy;
  endsequence
  sequence start_seen_s;
    conv_start && conv_busy;
  endsequence
  start_read_a: assert property (read_idle_s |=> start_seen_s)
    else $error("no start");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start too long");
  start_why_a: assert property (conv_start |-> $past(result_rd) && !$past(conv_busy))
    else $error("stray start");
  busy_done_a: assert property (result_rd && conv_busy |=> !result_rdata[31])
    else $error("done while busy");
  upper_zero_a: assert property (result_rd |=> result_rdata[30:16] == 15'h0000)
    else $error("upper bits");
  rdata_hold_a: assert property (!result_rd |=> $stable(result_rdata))
    else $error("data moved");
  conv_end_a: assert property ($rose(conv_busy) |-> ##[1:900] !conv_busy)
    else $error("no end");
endmodule
bind adcrt_top adcrt_sva chk_u (.clk, .rst, .result_rd, .result_rdata, .conv_start, .conv_busy);
`default_nettype wire

// ### verification/adcrt_sw_model.sv
// Software model: polls the result register.
// Assumes the bus clock of adcrt_top.
`timescale 1ns/100ps
`default_nettype none
module adcrt_sw_model (
  input  wire logic        clk,   // Clock
  input  wire logic [31:0] rdata, // Read data
  output logic             rd     // Read strobe
);
  initial rd = 1'b0;
  task automatic poll(output logic [31:0] w, output bit to);
    to = 1'b1;
    for (int n = 0; n < 900 && to; n++) begin
      @(negedge clk) rd = 1'b1;
      @(negedge clk) rd = 1'b0;
      w = rdata;
      to = w[31] !== 1'b1;
    end
  endtask
endmodule
`default_nettype wire
